// ### core/vectored_interrupt_logic.sv
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vil_map.svh"

module vectored_interrupt_logic
   import vil_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Avalon-MM slave
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Pins
   input wire logic ext_pin_in,
   input wire logic count_pin_in,
   input wire logic [7:0] port_pins_in,
   input wire logic port_latch_in,
   // Timers and peripherals
   input wire logic timer0_overflow_in,
   input wire timer8_t timer1_in,
   input wire timer8_t timer2_in,
   input wire timer16_t timer3_in,
   input wire logic timer_pair_wide_mode_in,
   input wire logic capture1_or_period_select_in,
   input wire periph_evt_t periph_in,
   // Core
   input wire logic instr_boundary_in,
   input wire logic return_from_isr_in,
   output logic irq_take_out,
   output logic push_return_out,
   output logic pop_return_out,
   output logic [15:0] vector_addr_out,
   output logic global_irq_disable_out,
   output logic wake_out
);

   // ----------
   // Helpers
   // ----------
   function automatic logic rolls8(input timer8_t t);
      rolls8 = t.tick && (t.count == t.period);
   endfunction

   function automatic logic is_write(input logic [7:0] idx,
                                     input logic [7:0] addr,
                                     input logic acc);
      is_write = acc && (addr == idx);
   endfunction

   // ----------
   // Declarations
   // ----------
   localparam int NPIN = 10;
   logic [NPIN-1:0] pin_raw, sync1_q, sync2_q, sync3_q, pin_q, pin_prev_q;
   logic ack_q, req, wr_go, global_irq_disable_q;
   logic ext_pin_edge_select_q, count_pin_edge_select_q;
   logic ext_evt, count_evt, periph_pending_summary, t1_evt, t2_evt, t3_evt;
   logic req_ext, req_t0, req_count, req_periph, any_req;
   logic race_zero, race_zero_q, take;
   logic [2:0] core_set;
   logic [3:0] en_cleared;
   logic [6:0] core_irq_status_q;
   logic [7:0] wbyte, rd_mux, flags_low_q, flags_high_q, enable_low_q;
   logic [7:0] enable_high_q, port_ref_q, set_low, set_high;
   logic [15:0] pair_count, pair_period, vec_d, vector_q;
   logic [31:0] rdata_q;
   seq_state_t state_q;

   // ----------
   // Pin synchronisers
   // ----------
   assign pin_raw = {port_pins_in, count_pin_in, ext_pin_in};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge mclk_in) begin
            if (rst_in) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
               sync3_q[gi] <= 1'b0;
               pin_q[gi] <= 1'b0;
               pin_prev_q[gi] <= 1'b0;
            end else begin
               sync1_q[gi] <= pin_raw[gi];
               sync2_q[gi] <= sync1_q[gi];
               sync3_q[gi] <= sync2_q[gi];
               if (sync2_q[gi] == sync3_q[gi]) begin
                  pin_q[gi] <= sync3_q[gi];
               end
               pin_prev_q[gi] <= pin_q[gi];
            end
         end
      end
   endgenerate

   // [RULE_10] Ext pin edge
   assign ext_evt = ext_pin_edge_select_q ? (pin_q[0] & ~pin_prev_q[0])
                                          : (~pin_q[0] & pin_prev_q[0]);
   // [RULE_11] Count pin edge
   assign count_evt = count_pin_edge_select_q
                      ? (pin_q[1] & ~pin_prev_q[1])
                      : (~pin_q[1] & pin_prev_q[1]);

   // ----------
   // Avalon slave, one wait state
   // ----------
   assign req = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & ~ack_q;
   assign wr_go = avs_write_in & ack_q & avs_byteenable_in[0];
   assign wbyte = avs_writedata_in[7:0];
   assign avs_readdata_out = rdata_q;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   always_comb begin
      case (avs_address_in)
         `IDX_TIMER0_STATUS: rd_mux = {ext_pin_edge_select_q,
                                       count_pin_edge_select_q, 6'h00};
         `IDX_CORE_STATUS: rd_mux = 8'(global_irq_disable_q)
                                    << `BIT_GLOBAL_DISABLE;
         // [RULE_12] Summary read-only
         `IDX_CORE_IRQ_STATUS: rd_mux = {periph_pending_summary,
                                         core_irq_status_q};
         `IDX_PERIPH_FLAGS_LOW: rd_mux = flags_low_q;
         // [RULE_14] Unused bit zero
         `IDX_PERIPH_FLAGS_HIGH: rd_mux = flags_high_q & `RMASK_HIGH;
         `IDX_PERIPH_ENABLE_LOW: rd_mux = enable_low_q;
         `IDX_PERIPH_ENABLE_HIGH: rd_mux = enable_high_q & `RMASK_HIGH;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read_in & ~ack_q) begin
         rdata_q <= {24'h00_0000, rd_mux};
      end
   end

   // ----------
   // Control registers
   // ----------
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         ext_pin_edge_select_q <= 1'b0;
         count_pin_edge_select_q <= 1'b0;
      end else if (is_write(`IDX_TIMER0_STATUS, avs_address_in, wr_go)) begin
         ext_pin_edge_select_q <= wbyte[`BIT_EXT_EDGE];
         count_pin_edge_select_q <= wbyte[`BIT_COUNT_EDGE];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         // [RULE_03] Disabled after reset
         global_irq_disable_q <= 1'b1;
      end else if (take) begin
         // [RULE_06] Auto disable on accept
         global_irq_disable_q <= 1'b1;
      end else if (return_from_isr_in) begin
         // [RULE_05] Return re-enables
         global_irq_disable_q <= 1'b0;
      end else if (is_write(`IDX_CORE_STATUS, avs_address_in, wr_go)) begin
         global_irq_disable_q <= wbyte[`BIT_GLOBAL_DISABLE];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         enable_low_q <= 8'h00;
         enable_high_q <= 8'h00;
      end else begin
         if (is_write(`IDX_PERIPH_ENABLE_LOW, avs_address_in, wr_go)) begin
            enable_low_q <= wbyte;
         end
         if (is_write(`IDX_PERIPH_ENABLE_HIGH, avs_address_in, wr_go)) begin
            enable_high_q <= wbyte & `RMASK_HIGH;
         end
      end
   end

   // ----------
   // Peripheral event sources
   // ----------
   assign pair_count = {timer2_in.count, timer1_in.count};
   assign pair_period = {timer2_in.period, timer1_in.period};

   // [RULE_17] Timer1 rollover
   assign t1_evt = timer_pair_wide_mode_in
                   ? (timer1_in.tick && pair_count == pair_period)
                   : rolls8(timer1_in);
   // [RULE_18] Timer2 rollover
   assign t2_evt = ~timer_pair_wide_mode_in & rolls8(timer2_in);
   // [RULE_16] Timer3 overflow or period
   assign t3_evt = timer3_in.tick &&
                   (capture1_or_period_select_in
                    ? (timer3_in.count == 16'hffff)
                    : (timer3_in.count == timer3_in.period));

   // [RULE_15] Port mismatch
   assign set_low[7] = |(pin_q[9:2] ^ port_ref_q);
   assign set_low[6] = t3_evt;
   assign set_low[5] = t2_evt;
   assign set_low[4] = t1_evt;
   // [RULE_19] Capture events
   assign set_low[3:2] = periph_in.capture[1:0];
   assign set_low[1:0] = 2'b00;
   // [RULE_21] Sync port and collision
   assign set_high[7] = periph_in.sync_done;
   assign set_high[6] = periph_in.collision;
   // [RULE_22] Conversion done
   assign set_high[5] = periph_in.conv_done;
   assign set_high[4] = 1'b0;
   assign set_high[3:2] = periph_in.capture[3:2];
   assign set_high[1:0] = 2'b00;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         port_ref_q <= 8'h00;
      end else if (port_latch_in) begin
         port_ref_q <= pin_q[9:2];
      end
   end

   // ----------
   // Peripheral flag registers
   // ----------
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         // [RULE_13] Low register resets
         flags_low_q <= `RST_FLAGS_LOW;
         // [RULE_14] High register resets
         flags_high_q <= `RST_FLAGS_HIGH;
      end else begin
         // [RULE_01] Set ignores enables
         if (is_write(`IDX_PERIPH_FLAGS_LOW, avs_address_in, wr_go)) begin
            flags_low_q[7:2] <= wbyte[7:2] | set_low[7:2];
         end else begin
            flags_low_q[7:2] <= flags_low_q[7:2] | set_low[7:2];
         end
         if (is_write(`IDX_PERIPH_FLAGS_HIGH, avs_address_in, wr_go)) begin
            flags_high_q[7:2] <= (wbyte[7:2] & 6'h3b) | set_high[7:2];
         end else begin
            flags_high_q[7:2] <= flags_high_q[7:2] | set_high[7:2];
         end
         // [RULE_20] Serial flags follow hardware
         flags_low_q[1:0] <= {periph_in.tx_empty[0], periph_in.rx_full[0]};
         flags_high_q[1:0] <= {periph_in.tx_empty[1], periph_in.rx_full[1]};
      end
   end

   // [RULE_12] Masked OR summary
   assign periph_pending_summary = |(flags_low_q & enable_low_q) |
                                   |(flags_high_q & enable_high_q &
                                     `RMASK_HIGH);

   // ----------
   // Core flags and enables
   // ----------
   assign core_set = {count_evt, timer0_overflow_in, ext_evt};

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         core_irq_status_q <= 7'h00;
      end else begin
         if (is_write(`IDX_CORE_IRQ_STATUS, avs_address_in, wr_go)) begin
            core_irq_status_q <= wbyte[6:0];
         end
         // [RULE_23] Auto clear on vector
         if (take && vec_d == `VEC_EXT) begin
            core_irq_status_q[`BIT_EXT_FLAG] <= 1'b0;
         end
         if (take && vec_d == `VEC_T0) begin
            core_irq_status_q[`BIT_T0_FLAG] <= 1'b0;
         end
         if (take && vec_d == `VEC_COUNT) begin
            core_irq_status_q[`BIT_COUNT_FLAG] <= 1'b0;
         end
         // [RULE_01] Set wins over clear
         if (core_set[0]) begin
            core_irq_status_q[`BIT_EXT_FLAG] <= 1'b1;
         end
         if (core_set[1]) begin
            core_irq_status_q[`BIT_T0_FLAG] <= 1'b1;
         end
         if (core_set[2]) begin
            core_irq_status_q[`BIT_COUNT_FLAG] <= 1'b1;
         end
      end
   end

   // ----------
   // Request gating and priority
   // ----------
   assign req_ext = core_irq_status_q[`BIT_EXT_FLAG] &
                    core_irq_status_q[`BIT_EXT_EN];
   assign req_t0 = core_irq_status_q[`BIT_T0_FLAG] &
                   core_irq_status_q[`BIT_T0_EN];
   assign req_count = core_irq_status_q[`BIT_COUNT_FLAG] &
                      core_irq_status_q[`BIT_COUNT_EN];
   // [RULE_04] Group enable masks peripherals
   assign req_periph = periph_pending_summary &
                       core_irq_status_q[`BIT_GROUP_EN];
   assign any_req = req_ext | req_t0 | req_count | req_periph;

   // [RULE_24] Enable cleared as flag sets
   assign en_cleared = is_write(`IDX_CORE_IRQ_STATUS, avs_address_in, wr_go)
                       ? (core_irq_status_q[3:0] & ~wbyte[3:0]) : 4'h0;
   assign race_zero = ~global_irq_disable_q &
                      ((en_cleared[0] & core_set[0]) |
                       (en_cleared[1] & core_set[1]) |
                       (en_cleared[2] & core_set[2]) |
                       (en_cleared[3] & periph_pending_summary));

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         race_zero_q <= 1'b0;
      end else if (race_zero) begin
         race_zero_q <= 1'b1;
      end else if (take) begin
         race_zero_q <= 1'b0;
      end
   end

   // [RULE_07] Vector table
   // [RULE_08] Fixed priority order
   always_comb begin
      if (race_zero_q) begin
         vec_d = `VEC_RESET;
      end else if (req_ext) begin
         vec_d = `VEC_EXT;
      end else if (req_t0) begin
         vec_d = `VEC_T0;
      end else if (req_count) begin
         vec_d = `VEC_COUNT;
      end else begin
         vec_d = `VEC_PERIPH;
      end
   end

   // [RULE_02] Global disable gates all requests except race_zero_q
   // [RULE_25] Only at instruction boundary
   assign take = (state_q == ST_RUN) & instr_boundary_in &
                 ((~global_irq_disable_q & any_req) | race_zero_q);

   // ----------
   // Vector sequencer
   // ----------
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         state_q <= ST_RUN;
      end else begin
         case (state_q)
            ST_RUN: begin
               if (take) begin
                  state_q <= ST_VECTOR;
               end
            end
            ST_VECTOR: state_q <= ST_RUN;
            default: state_q <= ST_RUN;
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         vector_q <= `VEC_RESET;
      end else if (take) begin
         vector_q <= vec_d;
      end
   end

   // [RULE_06] Push and load vector
   assign irq_take_out = (state_q == ST_VECTOR);
   assign push_return_out = (state_q == ST_VECTOR) & ~race_zero_q &
                            (vector_q != `VEC_RESET);
   // [RULE_05] Pop on return
   assign pop_return_out = return_from_isr_in;
   assign vector_addr_out = vector_q;
   assign global_irq_disable_out = global_irq_disable_q;
   // [RULE_10] Pins wake from sleep
   assign wake_out = req_ext | req_count | req_periph;

endmodule // vectored_interrupt_logic

`default_nettype wire

// ### core/vil_map.svh
// Overview of operation
// [RULE_01] Flags set regardless of enables
// [RULE_02] Global disable bit blocks all interrupts; the code takes the race_zero_q vector zero even while disabled
// [RULE_03] Reset sets global disable bit
// [RULE_04] Peripheral needs own and group enable
// [RULE_05] Return clears disable, pops stack
// [RULE_06] Accept sets disable, pushes, loads vector; the code pushes only for a nonzero vector with race_zero_q clear
// [RULE_07] Four fixed vectors with fixed priorities
// [RULE_08] Higher priority vector wins simultaneous requests
// [RULE_09] Software polls and clears peripheral flags
// [RULE_10] Ext pin edge selectable, sets flag
// [RULE_11] Count pin edge selectable, sets flag
// [RULE_12] Summary flag is masked OR, read-only
// [RULE_13] Low flag register layout and resets
// [RULE_14] High flag register layout and resets
// [RULE_15] Port change flag on input mismatch
// [RULE_16] Timer3 flag on overflow or period
// [RULE_17] Timer1 flag, eight or sixteen bit
// [RULE_18] Timer2 flag on period rollover
// [RULE_19] Capture flags set on capture events
// [RULE_20] Serial flags mirror buffer state
// [RULE_21] Sync port and collision flags
// [RULE_22] Converter flag on conversion done
// [RULE_23] Vectoring clears core flag, not peripheral
// [RULE_24] Flag set during enable clear vectors zero
// [RULE_25] Requests taken only at instruction boundary
`ifndef VIL_MAP_SVH
`define VIL_MAP_SVH

// ----------
// Register indexes (byte address = 4*index)
// ----------
`define IDX_TIMER0_STATUS 8'h05
`define IDX_CORE_STATUS 8'h06
`define IDX_CORE_IRQ_STATUS 8'h07
`define IDX_PERIPH_FLAGS_HIGH 8'h10
`define IDX_PERIPH_ENABLE_HIGH 8'h11
`define IDX_PERIPH_FLAGS_LOW 8'h16
`define IDX_PERIPH_ENABLE_LOW 8'h17

// ----------
// Field positions
// ----------
`define BIT_GLOBAL_DISABLE 4
`define BIT_EXT_EDGE 7
`define BIT_COUNT_EDGE 6
`define BIT_SUMMARY 7
`define BIT_COUNT_FLAG 6
`define BIT_T0_FLAG 5
`define BIT_EXT_FLAG 4
`define BIT_GROUP_EN 3
`define BIT_COUNT_EN 2
`define BIT_T0_EN 1
`define BIT_EXT_EN 0
`define HIGH_UNUSED_BIT 4

// ----------
// Reset values and write masks
// ----------
`define RST_FLAGS_LOW 8'h02
`define RST_FLAGS_HIGH 8'h02
`define WMASK_FLAGS 8'hfc
`define RMASK_HIGH 8'hef

// ----------
// Vectors
// ----------
`define VEC_RESET 16'h0000
`define VEC_EXT 16'h0008
`define VEC_T0 16'h0010
`define VEC_COUNT 16'h0018
`define VEC_PERIPH 16'h0020

`endif

// ### core/vil_pkg.sv
package vil_pkg;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_VECTOR = 2'b01
   } seq_state_t;

   typedef struct packed {
      logic tick;
      logic [7:0] count;
      logic [7:0] period;
   } timer8_t;

   typedef struct packed {
      logic tick;
      logic [15:0] count;
      logic [15:0] period;
   } timer16_t;

   typedef struct packed {
      logic [3:0] capture;
      logic sync_done;
      logic collision;
      logic conv_done;
      logic [1:0] tx_empty;
      logic [1:0] rx_full;
   } periph_evt_t;

endpackage

// ### tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Bench control
   input wire logic run_in,
   input wire logic ret_req_in,
   // Interrupt block side
   input wire logic push_in,
   input wire logic pop_in,
   input wire logic [15:0] vector_in,
   output logic boundary_out,
   output logic return_out,
   output logic [15:0] pc_out,
   output logic [3:0] sp_out
);
   logic phase_q;
   logic [15:0] stack_q [16];
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         phase_q <= 1'b0;
      end else if (run_in) begin
         phase_q <= ~phase_q;
      end
   end
   assign boundary_out = run_in & phase_q;
   // Return instruction pulse
   always_ff @(posedge mclk_in) begin
      return_out <= ret_req_in & ~rst_in;
   end
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         pc_out <= 16'h0000;
         sp_out <= 4'h0;
      end else if (push_in) begin
         stack_q[sp_out] <= pc_out;
         sp_out <= sp_out + 4'h1;
         pc_out <= vector_in;
      end else if (pop_in && sp_out != 4'h0) begin
         pc_out <= stack_q[sp_out - 4'h1];
         sp_out <= sp_out - 4'h1;
      end else if (boundary_out) begin
         pc_out <= pc_out + 16'h0001;
      end
   end
endmodule // core_model
`default_nettype wire

// ### tb/vectored_interrupt_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "vil_map.svh"
module vectored_interrupt_logic_tb
   import vil_pkg::*;
;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] adr = 8'h00;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wait_rq, ext_pin = 1'b0, cnt_pin = 1'b0, latch = 1'b0;
   logic [7:0] pins = 8'h00;
   logic t0_ovf = 1'b0;
   timer8_t tm1 = '0;
   timer8_t tm2 = '0;
   timer16_t tm3 = '0;
   periph_evt_t evt = '{4'h0, 1'b0, 1'b0, 1'b0, 2'b11, 2'b00};
   logic run = 1'b1, wide = 1'b0, csel = 1'b1;
   logic ret_req = 1'b0;
   logic boundary, ret, irq_take, push, pop, dis, wake, seen;
   logic [15:0] vec, pc;
   logic [3:0] sp;
   logic [7:0] rd;
   logic [15:0] vecs [4] = '{16'h0008, 16'h0010, 16'h0018, 16'h0020};
   int err_total = 0;
   int checks_done = 0;
   int cycles = 0;

   vectored_interrupt_logic u_dut (.mclk_in(mclk_in), .rst_in(rst_in),
      .avs_address_in(adr), .avs_read_in(rd_en), .avs_write_in(wr_en),
      .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq),
      .ext_pin_in(ext_pin), .count_pin_in(cnt_pin), .port_pins_in(pins),
      .port_latch_in(latch), .timer0_overflow_in(t0_ovf),
      .timer1_in(tm1), .timer2_in(tm2), .timer3_in(tm3),
      .timer_pair_wide_mode_in(wide), .capture1_or_period_select_in(csel),
      .periph_in(evt), .instr_boundary_in(boundary),
      .return_from_isr_in(ret), .irq_take_out(irq_take),
      .push_return_out(push), .pop_return_out(pop),
      .vector_addr_out(vec), .global_irq_disable_out(dis),
      .wake_out(wake));
   core_model u_core (.mclk_in(mclk_in), .rst_in(rst_in), .run_in(run),
      .ret_req_in(ret_req), .push_in(push), .pop_in(pop), .vector_in(vec),
      .boundary_out(boundary), .return_out(ret), .pc_out(pc),
      .sp_out(sp));

   always #5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 4000) begin
         err_total++;
         results();
      end
   end
   // ----------
   // Tasks
   // ----------
   task automatic results;
      if (err_total == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] idx,
         input logic [7:0] wd);
      @(posedge mclk_in);
      adr <= idx;
      wdata <= {24'h000000, wd};
      rd_en <= ~wr;
      wr_en <= wr;
      do @(posedge mclk_in);
      while (wait_rq !== 1'b0);
      rd = rdata[7:0];
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [7:0] mask,
         input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      check($sformatf("register %h", idx), {8'h00, exp}, {8'h00, rd & mask});
   endtask
   task automatic ret_idle(input logic run_on);
      @(posedge mclk_in);
      ret_req <= 1'b1;
      run <= run_on;
      @(posedge mclk_in);
      ret_req <= 1'b0;
      seen = 1'b0;
      repeat (7) begin
         @(posedge mclk_in);
         seen = seen | irq_take;
      end
      check("take while held", 16'h0000, {15'h0000, seen});
      check("disable after return", 16'h0000, {15'h0000, dis});
      run <= 1'b1;
   endtask
   task automatic wait_take(input logic [15:0] exp_vec);
      do @(posedge mclk_in);
      while (irq_take !== 1'b1);
      check("vector", exp_vec, vec);
      check("disable on take", 16'h0001, {15'h0000, dis});
      check("push on take", 16'h0001, {15'h0000, push});
      @(negedge mclk_in);
      check("pc after take", exp_vec, pc);
      check("stack depth", 16'h0001, {12'h000, sp});
   endtask
   // ----------
   // Sequence
   // ----------
   initial begin
      repeat (6) @(posedge mclk_in);
      rst_in <= 1'b0;
      repeat (6) @(posedge mclk_in);
      rchk(`IDX_CORE_STATUS, 8'h10, 8'h10);
      rchk(`IDX_CORE_IRQ_STATUS, 8'hff, 8'h00);
      rchk(`IDX_PERIPH_FLAGS_LOW, 8'hff, 8'h02);
      rchk(`IDX_PERIPH_FLAGS_HIGH, 8'hff, 8'h02);
      rchk(8'h3f, 8'hff, 8'h00);
      bus(1'b1, `IDX_PERIPH_FLAGS_LOW, 8'hff);
      bus(1'b1, `IDX_PERIPH_FLAGS_HIGH, 8'hff);
      rchk(`IDX_PERIPH_FLAGS_LOW, 8'hff, 8'hfe);
      rchk(`IDX_PERIPH_FLAGS_HIGH, 8'hff, 8'hee);
      bus(1'b1, `IDX_PERIPH_FLAGS_LOW, 8'h00);
      bus(1'b1, `IDX_PERIPH_FLAGS_HIGH, 8'h00);
      @(posedge mclk_in);
      evt.tx_empty <= 2'b00;
      evt.rx_full <= 2'b11;
      bus(1'b1, `IDX_PERIPH_FLAGS_LOW, 8'h02);
      rchk(`IDX_PERIPH_FLAGS_LOW, 8'h03, 8'h01);
      rchk(`IDX_PERIPH_FLAGS_HIGH, 8'h03, 8'h01);
      // Every peripheral source at once
      @(posedge mclk_in);
      latch <= 1'b1;
      evt <= '{4'hf, 1'b1, 1'b1, 1'b1, 2'b11, 2'b00};
      tm1 <= '{1'b1, 8'h07, 8'h07};
      tm2 <= '{1'b1, 8'h07, 8'h07};
      tm3 <= '{1'b1, 16'hffff, 16'h1234};
      @(posedge mclk_in);
      latch <= 1'b0;
      pins <= 8'h10;
      evt <= '{4'h0, 1'b0, 1'b0, 1'b0, 2'b11, 2'b00};
      tm1.tick <= 1'b0;
      tm2.tick <= 1'b0;
      tm3.tick <= 1'b0;
      repeat (8) @(posedge mclk_in);
      rchk(`IDX_PERIPH_FLAGS_LOW, 8'hff, 8'hfe);
      rchk(`IDX_PERIPH_FLAGS_HIGH, 8'hff, 8'hee);
      bus(1'b1, `IDX_PERIPH_FLAGS_LOW, 8'h7c);
      rchk(`IDX_PERIPH_FLAGS_LOW, 8'hff, 8'hfe);
      bus(1'b1, `IDX_PERIPH_ENABLE_LOW, 8'h04);
      rchk(`IDX_CORE_IRQ_STATUS, 8'hff, 8'h80);
      ret_idle(1'b1);
      bus(1'b1, `IDX_CORE_IRQ_STATUS, 8'h08);
      wait_take(16'h0020);
      check("wake", 16'h0001, {15'h0000, wake});
      bus(1'b1, `IDX_TIMER0_STATUS, 8'hc0);
      @(posedge mclk_in);
      ext_pin <= 1'b1;
      cnt_pin <= 1'b1;
      t0_ovf <= 1'b1;
      @(posedge mclk_in);
      t0_ovf <= 1'b0;
      repeat (8) @(posedge mclk_in);
      rchk(`IDX_CORE_IRQ_STATUS, 8'hff, 8'hf8);
      bus(1'b1, `IDX_CORE_IRQ_STATUS, 8'h7f);
      foreach (vecs[i]) begin
         ret_idle(1'b0);
         wait_take(vecs[i]);
      end
      rchk(`IDX_CORE_IRQ_STATUS, 8'hff, 8'h8f);
      rchk(`IDX_PERIPH_FLAGS_LOW, 8'hfc, 8'hfc);
      @(posedge mclk_in);
      pins <= 8'h00;
      repeat (8) @(posedge mclk_in);
      bus(1'b1, `IDX_PERIPH_FLAGS_LOW, 8'h00);
      bus(1'b1, `IDX_PERIPH_FLAGS_HIGH, 8'h00);
      rchk(`IDX_CORE_IRQ_STATUS, 8'hff, 8'h0f);
      check("wake idle", 16'h0000, {15'h0000, wake});
      @(posedge mclk_in);
      wide <= 1'b1;
      csel <= 1'b0;
      tm1 <= '{1'b1, 8'h34, 8'h34};
      tm2 <= '{1'b1, 8'h12, 8'h12};
      tm3 <= '{1'b1, 16'h00aa, 16'h00aa};
      rchk(`IDX_PERIPH_FLAGS_LOW, 8'hff, 8'h52);
      ret_idle(1'b1);
      @(negedge mclk_in);
      check("stack after return", 16'h0000, {12'h000, sp});
      results();
   end
endmodule // vectored_interrupt_logic_tb
`default_nettype wire

// ### tb/vil_checker.sv
`timescale 1ns/1ps
`default_nettype none
module vil_checker (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Bus
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic avs_waitrequest_out,
   // Core
   input wire logic instr_boundary_in,
   input wire logic return_from_isr_in,
   input wire logic irq_take_out,
   input wire logic push_return_out,
   input wire logic pop_return_out,
   input wire logic [15:0] vector_addr_out,
   input wire logic global_irq_disable_out
);
   wire logic req;
   assign req = avs_read_in | avs_write_in;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   // ----------
   // Bus handshake
   // ----------
   a_one_wait: assert property (req && avs_waitrequest_out |=>
      !avs_waitrequest_out) else $error("wait state not single");
   a_idle_ready: assert property (!req |-> !avs_waitrequest_out)
      else $error("waitrequest while idle");
   // ----------
   // Vectoring
   // ----------
   a_take_disables: assert property (irq_take_out |->
      global_irq_disable_out) else $error("take without disable");
   a_take_push: assert property (irq_take_out &&
      vector_addr_out != 16'h0000 |-> push_return_out)
      else $error("take without push");
   a_push_only: assert property (push_return_out |-> irq_take_out)
      else $error("push without take");
   a_vec_legal: assert property (irq_take_out |->
      vector_addr_out inside {16'h0000, 16'h0008, 16'h0010, 16'h0018,
      16'h0020}) else $error("illegal vector");
   a_take_boundary: assert property (irq_take_out |->
      $past(instr_boundary_in)) else $error("take off boundary");
   a_take_gap: assert property (irq_take_out |=> !irq_take_out)
      else $error("takes back to back");
   a_dis_blocks: assert property (irq_take_out && vector_addr_out !=
      16'h0000 |-> !$past(global_irq_disable_out))
      else $error("take while disabled");
   a_ret_pop: assert property (return_from_isr_in |->
      pop_return_out) else $error("return without pop");
   a_ret_enable: assert property (return_from_isr_in |=>
      !global_irq_disable_out || irq_take_out)
      else $error("return kept disable");
   a_dis_falls: assert property ($fell(global_irq_disable_out) |->
      $past(return_from_isr_in)) else $error("disable fell alone");
   a_vec_hold: assert property (1'b1 |=> irq_take_out ||
      $stable(vector_addr_out)) else $error("vector moved");
   c_take_ext: cover property (irq_take_out && vector_addr_out == 16'h0008);
   c_take_per: cover property (irq_take_out && vector_addr_out == 16'h0020);
   c_return: cover property (return_from_isr_in);
   c_write: cover property (avs_write_in && !avs_waitrequest_out);
endmodule // vil_checker

bind vectored_interrupt_logic vil_checker u_chk (.mclk_in, .rst_in,
   .avs_read_in, .avs_write_in, .avs_waitrequest_out, .instr_boundary_in,
   .return_from_isr_in, .irq_take_out, .push_return_out, .pop_return_out,
   .vector_addr_out, .global_irq_disable_out);
`default_nettype wire
